// ==== core/ccs_map.vh ====
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// clock and time base
`define CCS_CLK_MHZ          100
`define CCS_HALF_SEC_MS      500
`define CCS_HALF_SEC_CYC     (`CCS_HALF_SEC_MS * 1000 * `CCS_CLK_MHZ)

// safety timer figures for the nominal timing capacitor, in half-second ticks
`define CCS_TRICKLE_TO_MIN   25
`define CCS_TRICKLE_TO_HT    (`CCS_TRICKLE_TO_MIN * 60 * 1000 / `CCS_HALF_SEC_MS)
`define CCS_FAST_TO_HR       3
`define CCS_FAST_TO_HT       (`CCS_FAST_TO_HR * 3600 * 1000 / `CCS_HALF_SEC_MS)
`define CCS_CV_TO_HR         3
`define CCS_CV_TO_HT         (`CCS_CV_TO_HR * 3600 * 1000 / `CCS_HALF_SEC_MS)

// thermal loop recheck period and fault flash rate
`define CCS_TLOOP_CHECK_MS   1500
`define CCS_TLOOP_CHECK_HT   (`CCS_TLOOP_CHECK_MS / `CCS_HALF_SEC_MS)
`define CCS_FLASH_HZ         1
`define CCS_FLASH_HALF_HT    (1000 / (2 * `CCS_FLASH_HZ) / `CCS_HALF_SEC_MS)

// current command, full scale = programmed constant current
`define CCS_CUR_FULL         8'hFF
`define CCS_TLOOP_NUM        28
`define CCS_TLOOP_DEN        100
`define CCS_CUR_TLOOP        ((255 * `CCS_TLOOP_NUM) / `CCS_TLOOP_DEN)
`define CCS_CUR_STEP         8'h08
`define CCS_CUR_TRICKLE      8'h1A

// register map
`define CCS_REG_CFG          8'h00
`define CCS_REG_STAT         8'h04
`define CCS_REG_MON          8'h08
`define CCS_CFG_SCALE_LSB    0
`define CCS_CFG_SCALE_MSB    3
`define CCS_CFG_SCALE_RST    4'h1

`endif

// ==== core/ccs_sync2.v ====
`timescale 1ns/10ps
// two-stage synchroniser bank for asynchronous comparator and pin inputs
module ccs_sync2 #(
	parameter W = 1
) (
	input  wire         sys_clk,
	input  wire         rst,
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= async_in[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

	assign sync_out = sync_q;
endmodule

// ==== core/ccs_sequencer.v ====
// Summary of operation
// - thermal loop entry cuts current to 0.28
// - recheck every 1.5 s, step current up, or down if still hot
// - thermal loop entry threshold is 115 C
// - trickle longer than 25 minutes faults
// - trickle plus fast charge over 3 hours faults
// - CV entry clears timer, 3 hour limit
// - trickle timeout flashes output a at 1 Hz
// - timeouts scale linearly with capacitor value
// - grounded timing capacitor disables safety timer
// - over-voltage stops charge, resumes when cleared
// - over-voltage shows fault on both outputs
// - die shutdown halts, hysteresis resumes previous state
// - battery temperature checked before and during charge
// - hot battery suspends, resumes automatically
// - cold battery suspends until cold removed
// - hot and cold faults shown on outputs
// - comparators bound window at 0.30 and 0.6
// - enable cycle restarts in phase by voltage
// - termination sleeps until recharge threshold crossed
`timescale 1ns/10ps
`include "ccs_map.vh"

module ccs_sequencer #(
	parameter [31:0] HALF_SEC_CYC = `CCS_HALF_SEC_CYC
) (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        charge_enable,
	input  wire        die_over_tloop,
	input  wire        die_over_shutdown,
	input  wire        die_below_hyst,
	input  wire        batt_below_precond,
	input  wire        batt_at_regulation,
	input  wire        batt_over_ovp,
	input  wire        batt_below_recharge,
	input  wire        current_at_term,
	input  wire        ts_below_hot,
	input  wire        ts_above_cold,
	input  wire        timing_cap_grounded,
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	output reg  [7:0]  charge_current_cmd,
	output reg         charge_on,
	output reg         status_out_a_o,
	output reg         status_out_a_oe,
	output reg         status_out_b_o,
	output reg         status_out_b_oe
);
	localparam [5:0] ST_IDLE    = 6'h01;
	localparam [5:0] ST_TRICKLE = 6'h02;
	localparam [5:0] ST_CC      = 6'h04;
	localparam [5:0] ST_CV      = 6'h08;
	localparam [5:0] ST_DONE    = 6'h10;
	localparam [5:0] ST_FAULT   = 6'h20;

	wire [11:0] raw_in = {timing_cap_grounded, ts_above_cold, ts_below_hot, current_at_term,
		batt_below_recharge, batt_over_ovp, batt_at_regulation, batt_below_precond,
		die_below_hyst, die_over_shutdown, die_over_tloop, charge_enable};
	wire [11:0] s_in;

	ccs_sync2 #(.W(12)) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in (raw_in),
		.sync_out (s_in)
	);

	wire en_s      = s_in[0];
	wire tloop_s   = s_in[1];
	wire shut_s    = s_in[2];
	wire hyst_s    = s_in[3];
	wire precond_s = s_in[4];
	wire reg_s     = s_in[5];
	wire ovp_s     = s_in[6];
	wire rech_s    = s_in[7];
	wire term_s    = s_in[8];
	wire hot_s     = s_in[9];
	wire cold_s    = s_in[10];
	wire capgnd_s  = s_in[11];

	reg [5:0]  state_q;
	reg [5:0]  state_d;
	reg [31:0] div_q;
	reg        tick_q;
	reg [19:0] tmr_q;
	reg [19:0] tmr_d;
	reg        ot_q;
	reg        flash_en_q;
	reg        flash_q;
	reg [1:0]  chk_q;
	reg        tloop_act_q;
	reg [7:0]  tloop_cur_q;
	reg [3:0]  cap_scale_q;

	// half-second time base
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_q  <= 32'h0;
			tick_q <= 1'b0;
		end else if (div_q >= HALF_SEC_CYC - 32'h1) begin
			div_q  <= 32'h0;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	// die shutdown latches until the hysteresis comparator reports cool
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ot_q <= 1'b0;
		end else if (shut_s) begin
			ot_q <= 1'b1;
		end else if (hyst_s) begin
			ot_q <= 1'b0;
		end
	end

	// window comparators sit outside at 0.30 and 0.6 of input voltage
	wire batt_temp_bad = hot_s | cold_s;
	wire suspend       = ovp_s | ot_q | batt_temp_bad;
	wire charging      = (state_q == ST_TRICKLE) | (state_q == ST_CC) | (state_q == ST_CV);

	wire        tmr_off   = capgnd_s | (cap_scale_q == 4'h0);
	wire [31:0] scale32   = {28'h0, cap_scale_q};
	wire [31:0] lim_trk   = `CCS_TRICKLE_TO_HT * scale32;
	wire [31:0] lim_fast  = `CCS_FAST_TO_HT * scale32;
	wire [31:0] lim_cv    = `CCS_CV_TO_HT * scale32;
	wire [31:0] tmr32     = {12'h0, tmr_q};
	wire        to_trk    = ~tmr_off & (tmr32 >= lim_trk);
	wire        to_fast   = ~tmr_off & (tmr32 >= lim_fast);
	wire        to_cv     = ~tmr_off & (tmr32 >= lim_cv);
	wire [5:0]  fresh_ph  = precond_s ? ST_TRICKLE : ST_CC;

	// phase sequencer; suspension freezes the phase so it resumes where it was
	always @* begin
		state_d = state_q;
		tmr_d   = tmr_q;
		if (tick_q && charging && !suspend && !tmr_off && tmr_q != 20'hFFFFF) begin
			tmr_d = tmr_q + 20'h1;
		end
		case (state_q)
			ST_IDLE: begin
				if (!batt_temp_bad && !ovp_s && !ot_q) begin
					state_d = fresh_ph;
					tmr_d   = 20'h0;
				end
			end
			ST_TRICKLE: begin
				if (to_trk) begin
					state_d = ST_FAULT;
				end else if (!suspend && !precond_s) begin
					state_d = ST_CC;
				end
			end
			ST_CC: begin
				if (to_fast) begin
					state_d = ST_FAULT;
				end else if (!suspend && reg_s) begin
					state_d = ST_CV;
					tmr_d   = 20'h0;
				end
			end
			ST_CV: begin
				if (to_cv) begin
					state_d = ST_FAULT;
				end else if (!suspend && term_s) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				if (rech_s) begin
					state_d = fresh_ph;
					tmr_d   = 20'h0;
				end
			end
			ST_FAULT: begin
				state_d = ST_FAULT;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		if (!en_s) begin
			state_d = ST_IDLE;
			tmr_d   = 20'h0;
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			tmr_q   <= 20'h0;
		end else begin
			state_q <= state_d;
			tmr_q   <= tmr_d;
		end
	end

	// trickle timeout flash: toggle every half second for 1 Hz, 50 percent duty
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flash_en_q <= 1'b0;
			flash_q    <= 1'b0;
		end else if (!en_s) begin
			flash_en_q <= 1'b0;
			flash_q    <= 1'b0;
		end else begin
			if (state_q == ST_TRICKLE && to_trk) begin
				flash_en_q <= 1'b1;
			end
			if (flash_en_q && tick_q) begin
				flash_q <= ~flash_q;
			end
		end
	end

	// thermal loop: cut to reduced level, then re-evaluate every 1.5 s
	wire [8:0] cur_up = {1'b0, tloop_cur_q} + {1'b0, `CCS_CUR_STEP};
	wire [31:0] cur_lo32 = `CCS_CUR_TLOOP;
	wire [7:0]  cur_lo   = cur_lo32[7:0];
	wire [8:0] cur_dn = {1'b0, tloop_cur_q} - {1'b0, `CCS_CUR_STEP};

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tloop_act_q <= 1'b0;
			tloop_cur_q <= `CCS_CUR_FULL;
			chk_q       <= 2'h0;
		end else if (!charging) begin
			tloop_act_q <= 1'b0;
			tloop_cur_q <= `CCS_CUR_FULL;
			chk_q       <= 2'h0;
		end else if (!tloop_act_q) begin
			if (tloop_s) begin
				tloop_act_q <= 1'b1;
				tloop_cur_q <= cur_lo;
				chk_q       <= 2'h0;
			end
		end else if (tick_q) begin
			if (chk_q == `CCS_TLOOP_CHECK_HT - 1) begin
				chk_q <= 2'h0;
				if (tloop_s) begin
					// still hot: back off one step, equilibrium found
					tloop_cur_q <= (cur_dn[8] || cur_dn[7:0] < cur_lo) ? cur_lo : cur_dn[7:0];
				end else if (cur_up[8] || cur_up[7:0] == `CCS_CUR_FULL) begin
					tloop_cur_q <= `CCS_CUR_FULL;
					tloop_act_q <= 1'b0;
				end else begin
					tloop_cur_q <= cur_up[7:0];
				end
			end else begin
				chk_q <= chk_q + 2'h1;
			end
		end
	end

	// current command and status drive
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			charge_current_cmd <= 8'h00;
			charge_on          <= 1'b0;
			status_out_a_o     <= 1'b0;
			status_out_a_oe    <= 1'b0;
			status_out_b_o     <= 1'b0;
			status_out_b_oe    <= 1'b0;
		end else begin
			status_out_a_o <= 1'b0;
			status_out_b_o <= 1'b0;
			if (!charging || suspend) begin
				charge_current_cmd <= 8'h00;
				charge_on          <= 1'b0;
			end else if (state_q == ST_TRICKLE) begin
				charge_current_cmd <= `CCS_CUR_TRICKLE;
				charge_on          <= 1'b1;
			end else begin
				charge_current_cmd <= tloop_act_q ? tloop_cur_q : `CCS_CUR_FULL;
				charge_on          <= 1'b1;
			end
			if (suspend || (state_q == ST_FAULT && !flash_en_q)) begin
				status_out_a_oe <= 1'b0;
				status_out_b_oe <= 1'b0;
			end else if (flash_en_q) begin
				status_out_a_oe <= flash_q;
				status_out_b_oe <= 1'b0;
			end else begin
				status_out_a_oe <= charging;
				status_out_b_oe <= (state_q == ST_DONE);
			end
		end
	end

	// register port
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cap_scale_q <= `CCS_CFG_SCALE_RST;
		end else if (reg_wr && reg_addr == `CCS_REG_CFG) begin
			cap_scale_q <= reg_wdata[`CCS_CFG_SCALE_MSB:`CCS_CFG_SCALE_LSB];
		end
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				`CCS_REG_CFG:  reg_rdata <= {28'h0, cap_scale_q};
				`CCS_REG_STAT: reg_rdata <= {18'h0, tmr_off, flash_en_q, tloop_act_q,
					batt_temp_bad, ot_q, ovp_s, cold_s, hot_s, state_q};
				`CCS_REG_MON:  reg_rdata <= {4'h0, tmr_q, charge_current_cmd};
				default:       reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end
endmodule

// ==== verif/ccs_sequencer_props.sv ====
`timescale 1ns/10ps
module ccs_sequencer_props #(
	parameter [31:0] HALF_SEC_CYC = 32'hA
) (
	input wire        sys_clk,
	input wire        rst,
	input wire        die_over_shutdown,
	input wire        batt_over_ovp,
	input wire        ts_below_hot,
	input wire        ts_above_cold,
	input wire [7:0]  reg_addr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	input wire [7:0]  charge_current_cmd,
	input wire        status_out_a_oe,
	input wire        status_out_b_oe
);
	reg  [7:0]  prev_q;
	reg  [31:0] gap_q;
	wire [7:0]  cmd = charge_current_cmd;
	wire        off = cmd == 8'h00 && !status_out_a_oe && !status_out_b_oe;
	wire        stp = cmd != prev_q && prev_q > 8'h47 && prev_q != 8'hFF && cmd >= 8'h47;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// cycles the current command has stood unchanged
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prev_q <= 8'h00;
			gap_q  <= 32'h0;
		end else begin
			prev_q <= cmd;
			gap_q  <= (cmd != prev_q) ? 32'h0 : gap_q + 32'h1;
		end
	end
	property p_ovp; batt_over_ovp [*5] |-> off; endproperty
	a_ovp: assert property (p_ovp) else $error("ovp did not suspend");
	property p_hot; ts_below_hot [*5] |-> off; endproperty
	a_hot: assert property (p_hot) else $error("hot did not suspend");
	property p_cold; ts_above_cold [*5] |-> off; endproperty
	a_cold: assert property (p_cold) else $error("cold did not suspend");
	property p_die; die_over_shutdown [*5] |-> off; endproperty
	a_die: assert property (p_die) else $error("die shutdown did not halt");
	property p_lvl; cmd == 8'h00 || cmd == 8'h1A || (cmd >= 8'h47 && cmd[2:0] == 3'h7); endproperty
	a_lvl: assert property (p_lvl) else $error("illegal current command");
	property p_step; stp |-> (cmd == prev_q + 8'h08 || cmd == prev_q - 8'h08) && gap_q < 4 * HALF_SEC_CYC; endproperty
	a_step: assert property (p_step) else $error("bad thermal step");
	property p_done; status_out_b_oe |-> cmd == 8'h00 && !status_out_a_oe; endproperty
	a_done: assert property (p_done) else $error("complete while charging");
	property p_rdat; !reg_rd || reg_addr > 8'h08 |=> reg_rdata == 32'h0; endproperty
	a_rdat: assert property (p_rdat) else $error("read data not zero");
endmodule

bind ccs_sequencer ccs_sequencer_props #(.HALF_SEC_CYC(HALF_SEC_CYC)) u_props (
	.sys_clk            (sys_clk),
	.rst                (rst),
	.die_over_shutdown  (die_over_shutdown),
	.batt_over_ovp      (batt_over_ovp),
	.ts_below_hot       (ts_below_hot),
	.ts_above_cold      (ts_above_cold),
	.reg_addr           (reg_addr),
	.reg_rd             (reg_rd),
	.reg_rdata          (reg_rdata),
	.charge_current_cmd (charge_current_cmd),
	.status_out_a_oe    (status_out_a_oe),
	.status_out_b_oe    (status_out_b_oe)
);

// ==== verif/tb_ccs_sequencer.sv ====
`timescale 1ns/10ps
module tb_ccs_sequencer;
	localparam HS = 2;
	reg         sys_clk = 1'h0;
	reg         rst = 1'h1;
	reg         charge_enable = 1'h0;
	reg         die_over_tloop = 1'h0;
	reg         die_over_shutdown = 1'h0;
	reg         die_below_hyst = 1'h0;
	reg         batt_below_precond = 1'h0;
	reg         batt_at_regulation = 1'h0;
	reg         batt_over_ovp = 1'h0;
	reg         batt_below_recharge = 1'h0;
	reg         current_at_term = 1'h0;
	reg         ts_below_hot = 1'h0;
	reg         ts_above_cold = 1'h0;
	reg         timing_cap_grounded = 1'h0;
	reg  [7:0]  reg_addr = 8'h00;
	reg  [31:0] reg_wdata = 32'h0;
	reg         reg_wr = 1'h0;
	reg         reg_rd = 1'h0;
	wire [31:0] reg_rdata;
	wire [7:0]  charge_current_cmd;
	wire        charge_on;
	wire        status_out_a_o;
	wire        status_out_a_oe;
	wire        status_out_b_o;
	wire        status_out_b_oe;
	integer     bad_count = 0;
	integer     n_tests = 0;
	integer     seed = 38;
	integer     i;
	reg  [31:0] d;
	reg         f;
	ccs_sequencer #(.HALF_SEC_CYC(HS)) uut (
		.sys_clk             (sys_clk),
		.rst                 (rst),
		.charge_enable       (charge_enable),
		.die_over_tloop      (die_over_tloop),
		.die_over_shutdown   (die_over_shutdown),
		.die_below_hyst      (die_below_hyst),
		.batt_below_precond  (batt_below_precond),
		.batt_at_regulation  (batt_at_regulation),
		.batt_over_ovp       (batt_over_ovp),
		.batt_below_recharge (batt_below_recharge),
		.current_at_term     (current_at_term),
		.ts_below_hot        (ts_below_hot),
		.ts_above_cold       (ts_above_cold),
		.timing_cap_grounded (timing_cap_grounded),
		.reg_addr            (reg_addr),
		.reg_wdata           (reg_wdata),
		.reg_wr              (reg_wr),
		.reg_rd              (reg_rd),
		.reg_rdata           (reg_rdata),
		.charge_current_cmd  (charge_current_cmd),
		.charge_on           (charge_on),
		.status_out_a_o      (status_out_a_o),
		.status_out_a_oe     (status_out_a_oe),
		.status_out_b_o      (status_out_b_o),
		.status_out_b_oe     (status_out_b_oe)
	);
	always #5 sys_clk = ~sys_clk;
	task cyc(input integer n);
		begin
			repeat (n) @(posedge sys_clk);
			#1;
		end
	endtask
	task chk(input [79:0] nm, input [31:0] e, input [31:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("Error %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task outs(input [7:0] c, input a, input b);
		begin
			chk("cmd", c, charge_current_cmd);
			chk("charge_on", c != 8'h00, charge_on);
			chk("stat_a", a, status_out_a_oe);
			chk("stat_b", b, status_out_b_oe);
			chk("stat_a_o", 1'h0, status_out_a_o);
			chk("stat_b_o", 1'h0, status_out_b_o);
		end
	endtask
	// thermal loop levels: 0.28 of full scale, then steps of 8
	function [7:0] tl_cur(input integer n);
		integer v;
		begin
			v = (255 * 28) / 100 + 8 * n;
			tl_cur = v[7:0];
		end
	endfunction
	task wr(input [7:0] a, input [31:0] v);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_wdata <= v;
			reg_wr <= 1'h1;
			@(posedge sys_clk);
			reg_wr <= 1'h0;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge sys_clk);
			reg_addr <= a;
			reg_rd <= 1'h1;
			@(posedge sys_clk);
			reg_rd <= 1'h0;
			#1 d = reg_rdata;
		end
	endtask
	task susp(input integer k);
		begin
			{ts_above_cold, ts_below_hot, batt_over_ovp, die_over_shutdown} <= 4'h1 << k;
			cyc(6 + {$random(seed)} % 4);
			outs(8'h00, 1'h0, 1'h0);
			{ts_above_cold, ts_below_hot, batt_over_ovp, die_over_shutdown} <= 4'h0;
			cyc(6);
			if (k == 0) begin
				outs(8'h00, 1'h0, 1'h0);
				die_below_hyst <= 1'h1;
				cyc(6);
				die_below_hyst <= 1'h0;
			end
			outs(8'hFF, 1'h1, 1'h0);
		end
	endtask
	task run(input p, input [3:0] s, input g, input integer t, input [7:0] c);
		begin
			charge_enable <= 1'h0;
			batt_below_precond <= p;
			timing_cap_grounded <= g;
			wr(8'h00, {28'h0, s});
			cyc(4);
			charge_enable <= 1'h1;
			cyc(t * HS * s - 10);
			chk("cmd_early", c, charge_current_cmd);
			cyc(40);
			chk("cmd_late", g ? c : 8'h00, charge_current_cmd);
			chk("stat_b", 1'h0, status_out_b_oe);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d errors %0d", n_tests, bad_count);
			if (bad_count == 0 && n_tests > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		#1000000;
		bad_count = bad_count + 1;
		finish_test;
	end
	initial begin
		cyc(8);
		outs(8'h00, 1'h0, 1'h0);
		rst <= 1'h0;
		rd(8'h00);
		chk("cfg", 32'h1, d);
		rd(8'h0C + {$random(seed)} % 8'hF0);
		chk("unmapped", 32'h0, d);
		wr(8'h04, 32'hFFFFFFFF);
		rd(8'h04);
		chk("stat_idle", 32'h01, d & 32'h3F);
		charge_enable <= 1'h1;
		cyc(6);
		outs(8'hFF, 1'h1, 1'h0);
		chk("charge_on", 1'h1, charge_on);
		die_over_tloop <= 1'h1;
		cyc(6);
		outs(tl_cur(0), 1'h1, 1'h0);
		die_over_tloop <= 1'h0;
		i = 0;
		while (charge_current_cmd === tl_cur(0) && i < 20) begin
			cyc(1);
			i = i + 1;
		end
		chk("step", tl_cur(1), charge_current_cmd);
		cyc(3 * HS * 23 + 20);
		chk("loop_end", 8'hFF, charge_current_cmd);
		for (i = 0; i < 8; i = i + 1)
			susp(i < 4 ? i : {$random(seed)} % 4);
		batt_at_regulation <= 1'h1;
		cyc(6);
		rd(8'h08);
		chk("cv_timer", 1'h1, d[27:8] < 20'h3);
		current_at_term <= 1'h1;
		cyc(6);
		outs(8'h00, 1'h0, 1'h1);
		current_at_term <= 1'h0;
		batt_at_regulation <= 1'h0;
		cyc(10);
		outs(8'h00, 1'h0, 1'h1);
		batt_below_recharge <= 1'h1;
		cyc(6);
		outs(8'hFF, 1'h1, 1'h0);
		batt_below_recharge <= 1'h0;
		run(1'h1, 4'h1, 1'h0, 3000, 8'h1A);
		f = status_out_a_oe;
		cyc(HS);
		chk("flash", {31'h0, ~f}, status_out_a_oe);
		cyc(HS);
		chk("flash", f, status_out_a_oe);
		run(1'h1, 4'h1, 1'h1, 3000, 8'h1A);
		run(1'h1, 4'h2, 1'h0, 3000, 8'h1A);
		run(1'h0, 4'h1, 1'h0, 21600, 8'hFF);
		finish_test;
	end
endmodule
